//--- shared/fgp_cfg.svh
// register map, field positions and reset values of the fast gpio port
`ifndef FGP_CFG_SVH
`define FGP_CFG_SVH

// ==========================================
// register offsets (byte addresses)
`define FGP_OFF_DIR      12'h000
`define FGP_OFF_PIN      12'h004
`define FGP_OFF_MASK     12'h008
`define FGP_OFF_MPIN     12'h00c
`define FGP_OFF_SET      12'h010
`define FGP_OFF_CLR      12'h014
`define FGP_OFF_TOGGLE   12'h018
`define FGP_OFF_FUNC     12'h01c
`define FGP_OFF_DIV_BASE 12'h020
`define FGP_OFF_PAD_BASE 12'h040

// ==========================================
// pad configuration fields
`define FGP_PAD_W        12
`define FGP_PAD_PULL_UP  0
`define FGP_PAD_PULL_DN  1
`define FGP_PAD_REPEAT   2
`define FGP_PAD_OD       3
`define FGP_PAD_INVERT   4
`define FGP_PAD_BYPASS   5
`define FGP_PAD_SEL_LO   6
`define FGP_PAD_SEL_HI   7
`define FGP_PAD_I2C_LO   8
`define FGP_PAD_I2C_HI   9
`define FGP_PAD_ANALOG   10
`define FGP_PAD_HYST     11

// ==========================================
// reset values and writable masks
`define FGP_PAD_RST_STD  12'h021
`define FGP_PAD_RST_OD   12'h020
`define FGP_PAD_WR_STD   12'h8ff
`define FGP_PAD_WR_OD    12'h3f0
`define FGP_PAD_WR_ANA   12'h400
`define FGP_DIV_W        8
`define FGP_DIV_RST      8'h00
`define FGP_FUNC_RST     32'hffff_ffd3
`define FGP_OD_PIN_A     10
`define FGP_OD_PIN_B     11
`define FGP_ANALOG_MASK  32'h0000_0000

`endif

//--- shared/fgp_pkg.sv
// shared types of the fast gpio port
package fgp_pkg;

	// ==========================================
	// types
	typedef enum logic [1:0] {
		FGP_DRV_STANDARD = 2'h0,
		FGP_DRV_I2C_FAST = 2'h1,
		FGP_DRV_I2C_PLUS = 2'h2
	} fgp_i2c_mode_type;

	typedef logic [11:0] fgp_pad_cfg_type;

endpackage

//--- rtl/fgp_glitch_filter.sv
// per-pin input glitch filter sampled on a divided clock enable
`timescale 1ns/1ps
`default_nettype none

module fgp_glitch_filter #(
	parameter int DEPTH = 3
) (
	input  wire logic sys_clk_in,
	input  wire logic rst_n_in,
	input  wire logic sample_in,
	input  wire logic bypass_in,
	input  wire logic data_in,
	output var  logic data_out
);

	// ==========================================
	// sample history
	logic [DEPTH-1:0] hist_reg;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			hist_reg <= {DEPTH{1'b1}};
		end else if (sample_in) begin
			hist_reg <= {hist_reg[DEPTH-2:0], data_in};
		end
	end

	// ==========================================
	// output: change only after depth equal samples, or at once when bypassed
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			data_out <= 1'b1;
		end else if (bypass_in) begin
			data_out <= data_in;
		end else if (&hist_reg) begin
			data_out <= 1'b1;
		end else if (~|hist_reg) begin
			data_out <= 1'b0;
		end
	end

endmodule
`default_nettype wire

//--- rtl/fgp_port.sv
// fast gpio port with pad configuration and function switch, apb slave
// Functional notes
// - each pin's direction is set on its own by software at run time.
// - set and clear writes change only the chosen output bits at once.
// - one write of the pin register updates all outputs together.
// - masked read and write touch only bits the mask leaves enabled.
// - every register access finishes with no wait state.
// - after reset pins are inputs with pull-up, open-drain pins without.
// - function switch enables port function at reset except debug and reset pins.
// - a port bit drives only its own pin; switch only enables or disables it.
// - a disabled port function frees the pin for movable functions.
// - standard pins have separate weak pull-up and pull-down enables.
// - pseudo open-drain mode drives low only and floats on high.
// - glitch filter picks a divided sample clock, or is bypassed per pin.
// - a per-pin bit inverts the input before port and peripherals.
// - standard pins offer a repeater mode enable.
// - analog mode cuts the digital input and output path.
// - open-drain pins select standard, i2c fast or i2c fast-plus drive.
`timescale 1ns/1ps
`default_nettype none
`include "fgp_cfg.svh"

module fgp_port
	import fgp_pkg::*;
#(
	parameter int           NUM_PINS    = 18,
	parameter int           NUM_DIV     = 4,
	parameter int           FILT_DEPTH  = 3,
	parameter logic [31:0]  ANALOG_MASK = `FGP_ANALOG_MASK
) (
	input  wire logic                  sys_clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [11:0]           paddr_in,
	input  wire logic [31:0]           pwdata_in,
	output var  logic [31:0]           prdata_out,
	output var  logic                  pready_out,
	output var  logic                  pslverr_out,
	input  wire logic [NUM_PINS-1:0]   pad_in_in,
	input  wire logic [NUM_PINS-1:0]   alt_out_in,
	input  wire logic [NUM_PINS-1:0]   alt_oe_in,
	output var  logic [NUM_PINS-1:0]   pad_out_out,
	output var  logic [NUM_PINS-1:0]   pad_oe_out,
	output var  logic [NUM_PINS-1:0]   pad_pull_up_out,
	output var  logic [NUM_PINS-1:0]   pad_pull_down_out,
	output var  logic [NUM_PINS-1:0]   pad_repeater_out,
	output var  logic [NUM_PINS-1:0]   pad_hysteresis_out,
	output var  logic [NUM_PINS-1:0]   pad_analog_out,
	output var  logic [3:0]            pad_i2c_mode_out,
	output var  logic [NUM_PINS-1:0]   func_en_out,
	output var  logic [NUM_PINS-1:0]   pin_level_out
);

	// ==========================================
	// declarations
	localparam int AW = 12;

	logic [NUM_PINS-1:0]   dir_reg;
	logic [NUM_PINS-1:0]   out_reg;
	logic [NUM_PINS-1:0]   mask_reg;
	logic [NUM_PINS-1:0]   func_reg;
	logic [NUM_PINS-1:0]   sync1_reg;
	logic [NUM_PINS-1:0]   sync2_reg;
	logic [NUM_PINS-1:0]   filt_q;
	logic [NUM_PINS-1:0]   level_next;
	logic [NUM_PINS-1:0]   oe_next;
	logic [NUM_PINS-1:0]   drv_next;
	logic [NUM_PINS-1:0]   wdat;
	logic [`FGP_DIV_W-1:0] div_reg [NUM_DIV];
	logic [`FGP_DIV_W-1:0] cnt_reg [NUM_DIV];
	logic [NUM_DIV-1:0]    tick;
	fgp_pad_cfg_type       pad_reg [NUM_PINS];
	logic                  setup;
	logic                  wr;
	logic                  hit_core;
	logic                  hit_div;
	logic                  hit_pad;
	logic [AW-1:0]         div_idx;
	logic [AW-1:0]         pad_idx;
	logic [31:0]           rdata_next;
	logic                  err_next;
	fgp_i2c_mode_type      i2c_a_mode;
	fgp_i2c_mode_type      i2c_b_mode;

	assign setup = psel_in & ~penable_in;
	assign wr    = psel_in & penable_in & pwrite_in;
	assign wdat  = pwdata_in[NUM_PINS-1:0];

	// ==========================================
	// address decode
	// unaligned addresses match nothing and answer with an error
	always_comb begin
		div_idx  = AW'((paddr_in - `FGP_OFF_DIV_BASE) >> 2);
		pad_idx  = AW'((paddr_in - `FGP_OFF_PAD_BASE) >> 2);
		hit_core = (paddr_in[1:0] == 2'h0) && (paddr_in < `FGP_OFF_DIV_BASE);
		hit_div  = (paddr_in[1:0] == 2'h0) && (paddr_in >= `FGP_OFF_DIV_BASE)
		           && (div_idx < AW'(NUM_DIV));
		hit_pad  = (paddr_in[1:0] == 2'h0) && (paddr_in >= `FGP_OFF_PAD_BASE)
		           && (pad_idx < AW'(NUM_PINS));
	end

	// ==========================================
	// apb answer: data prepared in setup, so no wait states
	// a write reads back zero; only the access edge commits it
	always_comb begin
		rdata_next = 32'h0000_0000;
		err_next   = 1'b0;
		case (paddr_in)
			`FGP_OFF_DIR:    rdata_next[NUM_PINS-1:0] = dir_reg;
			`FGP_OFF_PIN:    rdata_next[NUM_PINS-1:0] = pin_level_out;
			`FGP_OFF_MASK:   rdata_next[NUM_PINS-1:0] = mask_reg;
			`FGP_OFF_MPIN:   rdata_next[NUM_PINS-1:0] = pin_level_out & ~mask_reg;
			`FGP_OFF_SET:    rdata_next[NUM_PINS-1:0] = out_reg;
			`FGP_OFF_CLR:    rdata_next[NUM_PINS-1:0] = out_reg;
			`FGP_OFF_TOGGLE: rdata_next[NUM_PINS-1:0] = out_reg;
			`FGP_OFF_FUNC:   rdata_next[NUM_PINS-1:0] = func_reg;
			default: begin
				if (hit_div) begin
					rdata_next[`FGP_DIV_W-1:0] = div_reg[div_idx[$clog2(NUM_DIV)-1:0]];
				end else if (hit_pad) begin
					rdata_next[`FGP_PAD_W-1:0] = pad_reg[pad_idx[4:0]];
				end else begin
					err_next = 1'b1;
				end
			end
		endcase
		if (!hit_core && !hit_div && !hit_pad) begin
			err_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			prdata_out  <= 32'h0000_0000;
			pslverr_out <= 1'b0;
			pready_out  <= 1'b0;
		end else begin
			pready_out <= 1'b1;
			if (setup) begin
				prdata_out  <= pwrite_in ? 32'h0000_0000 : rdata_next;
				pslverr_out <= err_next;
			end
		end
	end

	// ==========================================
	// direction register
	// a clear bit leaves the pin an input
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			dir_reg <= '0;
		end else if (wr && paddr_in == `FGP_OFF_DIR) begin
			dir_reg <= wdat;
		end
	end

	// ==========================================
	// output latch: whole, masked, set, clear, toggle
	// toggle is an extra access that saves a read-modify-write on the bus
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			out_reg <= '0;
		end else if (wr) begin
			case (paddr_in)
				`FGP_OFF_PIN:    out_reg <= wdat;
				`FGP_OFF_MPIN:   out_reg <= (out_reg & mask_reg) | (wdat & ~mask_reg);
				`FGP_OFF_SET:    out_reg <= out_reg | wdat;
				`FGP_OFF_CLR:    out_reg <= out_reg & ~wdat;
				`FGP_OFF_TOGGLE: out_reg <= out_reg ^ wdat;
				default:         out_reg <= out_reg;
			endcase
		end
	end

	// ==========================================
	// mask register, a set bit hides the pin from masked access
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			mask_reg <= '0;
		end else if (wr && paddr_in == `FGP_OFF_MASK) begin
			mask_reg <= wdat;
		end
	end

	// ==========================================
	// function switch: one enable per fixed pin
	// pins 2, 3 and 5 keep their special functions out of reset
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			func_reg <= NUM_PINS'(`FGP_FUNC_RST);
		end else if (wr && paddr_in == `FGP_OFF_FUNC) begin
			func_reg <= wdat;
		end
	end

	// ==========================================
	// filter clock dividers
	generate
		for (genvar d = 0; d < NUM_DIV; d++) begin : g_div
			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in) begin
					div_reg[d] <= `FGP_DIV_RST;
				end else if (wr && hit_div && div_idx == AW'(d)) begin
					div_reg[d] <= pwdata_in[`FGP_DIV_W-1:0];
				end
			end

			// a new divide value takes effect at once; a count already past it wraps on the next cycle
			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in) begin
					cnt_reg[d] <= '0;
				end else if (cnt_reg[d] >= div_reg[d]) begin
					cnt_reg[d] <= '0;
				end else begin
					cnt_reg[d] <= cnt_reg[d] + `FGP_DIV_W'(1);
				end
			end

			assign tick[d] = (cnt_reg[d] >= div_reg[d]);
		end
	endgenerate

	// ==========================================
	// input synchroniser, two stages before anything looks
	// reset to the pulled-up idle level so no false low follows reset
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end else begin
			sync1_reg <= pad_in_in;
			sync2_reg <= sync1_reg;
		end
	end

	// ==========================================
	// per-pin pad configuration, filter and drive
	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
			localparam bit IS_OD  = (i == `FGP_OD_PIN_A) || (i == `FGP_OD_PIN_B);
			localparam bit IS_ANA = ANALOG_MASK[i];
			localparam logic [11:0] WMASK = IS_OD ? `FGP_PAD_WR_OD :
				(`FGP_PAD_WR_STD | (IS_ANA ? `FGP_PAD_WR_ANA : 12'h000));
			localparam logic [11:0] RST = IS_OD ? `FGP_PAD_RST_OD : `FGP_PAD_RST_STD;

			logic [1:0] sel;
			logic       ana;
			logic       use_port;
			logic       dir_i;
			logic       val_i;
			logic       od_i;
			logic       smp;

			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in) begin
					pad_reg[i] <= RST;
				end else if (wr && hit_pad && pad_idx == AW'(i)) begin
					pad_reg[i] <= pwdata_in[`FGP_PAD_W-1:0] & WMASK;
				end
			end

			assign sel      = pad_reg[i][`FGP_PAD_SEL_HI:`FGP_PAD_SEL_LO];
			assign ana      = pad_reg[i][`FGP_PAD_ANALOG];
			assign use_port = func_reg[i];
			// a disabled port bit hands the pin to the movable function
			assign dir_i    = use_port ? dir_reg[i] : alt_oe_in[i];
			assign val_i    = use_port ? out_reg[i] : alt_out_in[i];
			assign od_i     = IS_OD || pad_reg[i][`FGP_PAD_OD];
			// a select beyond the built dividers never samples, so the filter holds
			assign smp      = (32'(sel) < NUM_DIV) ? tick[sel] : 1'b0;

			// the filter sees only the synchronised level
			fgp_glitch_filter #(
				.DEPTH (FILT_DEPTH)
			) u_filt (
				.sys_clk_in (sys_clk_in),
				.rst_n_in   (rst_n_in),
				.sample_in  (smp),
				.bypass_in  (pad_reg[i][`FGP_PAD_BYPASS]),
				.data_in    (sync2_reg[i]),
				.data_out   (filt_q[i])
			);

			always_comb begin
				level_next[i] = ana ? 1'b0 : (filt_q[i] ^ pad_reg[i][`FGP_PAD_INVERT]);
				oe_next[i]    = ~ana & dir_i & (od_i ? ~val_i : 1'b1);
				drv_next[i]   = od_i ? 1'b0 : val_i;
			end
		end
	endgenerate

	// ==========================================
	// i2c drive mode of the open-drain pins; the spare code falls back to standard drive
	always_comb begin
		case (pad_reg[`FGP_OD_PIN_A][`FGP_PAD_I2C_HI:`FGP_PAD_I2C_LO])
			2'h1:    i2c_a_mode = FGP_DRV_I2C_FAST;
			2'h2:    i2c_a_mode = FGP_DRV_I2C_PLUS;
			default: i2c_a_mode = FGP_DRV_STANDARD;
		endcase
		case (pad_reg[`FGP_OD_PIN_B][`FGP_PAD_I2C_HI:`FGP_PAD_I2C_LO])
			2'h1:    i2c_b_mode = FGP_DRV_I2C_FAST;
			2'h2:    i2c_b_mode = FGP_DRV_I2C_PLUS;
			default: i2c_b_mode = FGP_DRV_STANDARD;
		endcase
	end

	// ==========================================
	// registered pad controls
	// every pad control leaves a flip-flop, so no decode glitch reaches a pin
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pad_out_out        <= '0;
			pad_oe_out         <= '0;
			pad_pull_up_out    <= '0;
			pad_pull_down_out  <= '0;
			pad_repeater_out   <= '0;
			pad_hysteresis_out <= '0;
			pad_analog_out     <= '0;
			pad_i2c_mode_out   <= 4'h0;
			func_en_out        <= '0;
			pin_level_out      <= '0;
		end else begin
			pad_out_out   <= drv_next;
			pad_oe_out    <= oe_next;
			pin_level_out <= level_next;
			func_en_out   <= func_reg;
			for (int k = 0; k < NUM_PINS; k++) begin
				pad_pull_up_out[k]    <= pad_reg[k][`FGP_PAD_PULL_UP];
				pad_pull_down_out[k]  <= pad_reg[k][`FGP_PAD_PULL_DN];
				pad_repeater_out[k]   <= pad_reg[k][`FGP_PAD_REPEAT];
				pad_hysteresis_out[k] <= pad_reg[k][`FGP_PAD_HYST];
				pad_analog_out[k]     <= pad_reg[k][`FGP_PAD_ANALOG];
			end
			pad_i2c_mode_out <= {i2c_b_mode, i2c_a_mode};
		end
	end

endmodule
`default_nettype wire

//--- sim/fgp_port_sva.sv
// assertions on the apb answer and pin outputs of the fast gpio port
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker
module fgp_port_sva #(
	parameter int NUM_PINS = 18
) (
	input  wire logic                sys_clk_in,
	input  wire logic                rst_n_in,
	input  wire logic                psel_in,
	input  wire logic                penable_in,
	input  wire logic                pwrite_in,
	input  wire logic [11:0]         paddr_in,
	input  wire logic [31:0]         pwdata_in,
	input  wire logic                pready_out,
	input  wire logic                pslverr_out,
	input  wire logic [NUM_PINS-1:0] pad_out_out,
	input  wire logic [NUM_PINS-1:0] pad_oe_out,
	input  wire logic [NUM_PINS-1:0] pad_pull_up_out,
	input  wire logic [NUM_PINS-1:0] func_en_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic wr_acc;
	assign wr_acc = psel_in && penable_in && pwrite_in;
	chk_ready_access: assert property (psel_in && penable_in |-> pready_out)
		else $error("wait state inserted");
	chk_ready_release: assert property ($rose(rst_n_in) |=> pready_out)
		else $error("not ready after reset");
	chk_reset_pullup: assert property ($rose(rst_n_in) |-> ##2 pad_pull_up_out == 18'h3f3ff && pad_oe_out == '0)
		else $error("reset pad state wrong");
	chk_reset_func: assert property ($rose(rst_n_in) |-> ##2 func_en_out == 18'h3ffd3)
		else $error("reset function switch wrong");
	chk_od_pins_low: assert property (pad_out_out[11:10] == 2'b00 && pad_pull_up_out[11:10] == 2'b00)
		else $error("open-drain pin driven high or pulled up");
	chk_dir_zero: assert property (wr_acc && paddr_in == 12'h000 && pwdata_in[17:0] == '0
		|-> ##2 (pad_oe_out & func_en_out) == '0) else $error("pin still driven after dir cleared");
	chk_pin_low: assert property (wr_acc && paddr_in == 12'h004
		|-> ##2 (pad_out_out & func_en_out & ~$past(pwdata_in[17:0], 2)) == '0) else $error("pin write missed");
	chk_clr_low: assert property (wr_acc && paddr_in == 12'h014
		|-> ##2 (pad_out_out & func_en_out & $past(pwdata_in[17:0], 2)) == '0) else $error("clear write missed");
	cover property (wr_acc && paddr_in == 12'h010);
	cover property (psel_in && penable_in && !pwrite_in && paddr_in == 12'h00c);
	cover property (pslverr_out);
endmodule
bind fgp_port fgp_port_sva #(.NUM_PINS(NUM_PINS)) chk_u (.sys_clk_in, .rst_n_in, .psel_in, .penable_in,
	.pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .pad_out_out, .pad_oe_out,
	.pad_pull_up_out, .func_en_out);
`default_nettype wire

//--- sim/fgp_pad_model.sv
// pad and board model giving the pin levels seen by the port
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// pad model
module fgp_pad_model #(
	parameter int NUM_PINS = 18
) (
	input  wire logic                sys_clk_in,
	input  wire logic [NUM_PINS-1:0] pad_out_in,
	input  wire logic [NUM_PINS-1:0] pad_oe_in,
	input  wire logic [NUM_PINS-1:0] pull_up_in,
	input  wire logic [NUM_PINS-1:0] pull_down_in,
	input  wire logic [NUM_PINS-1:0] ext_val_in,
	input  wire logic [NUM_PINS-1:0] ext_en_in,
	output var  logic [NUM_PINS-1:0] level_out
);
	// an unpulled floating pin wanders each cycle so no stale level can pass
	logic [NUM_PINS-1:0] float_reg = '0;
	always_ff @(posedge sys_clk_in) begin
		float_reg <= ~float_reg;
	end
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (pad_oe_in[i]) begin
				level_out[i] = pad_out_in[i];
			end else if (ext_en_in[i]) begin
				level_out[i] = ext_val_in[i];
			end else if (pull_up_in[i] || pull_down_in[i]) begin
				level_out[i] = pull_up_in[i];
			end else begin
				level_out[i] = float_reg[i];
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/test_fgp_port.sv
// self-checking bench for the fast gpio port
`timescale 1ns/1ps
`default_nettype none
`include "fgp_cfg.svh"
// ==========================================
// bench top
module test_fgp_port;
	logic        sys_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata, q;
	logic        pready, pslverr, err;
	logic [17:0] alt_out = 18'h00000;
	logic [17:0] alt_oe  = 18'h00000;
	logic [17:0] ext_val = 18'h00000;
	logic [17:0] ext_en  = 18'h00000;
	logic [17:0] pad_in, pad_out, pad_oe, pu, pd, rep, func_en, lvl, hys, ana;
	logic [3:0]  i2c;
	int          errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	fgp_port #(.ANALOG_MASK(32'h0000_0080)) dut_u (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .pad_in_in(pad_in), .alt_out_in(alt_out), .alt_oe_in(alt_oe),
		.pad_out_out(pad_out), .pad_oe_out(pad_oe), .pad_pull_up_out(pu), .pad_pull_down_out(pd),
		.pad_repeater_out(rep), .pad_hysteresis_out(hys), .pad_analog_out(ana), .pad_i2c_mode_out(i2c),
		.func_en_out(func_en), .pin_level_out(lvl));
	fgp_pad_model pad_u (.sys_clk_in(sys_clk), .pad_out_in(pad_out), .pad_oe_in(pad_oe), .pull_up_in(pu),
		.pull_down_in(pd), .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(pad_in));
	always #20 sys_clk = ~sys_clk;
	// ==========================================
	// shared tasks
	task test_done();
		$display("tests_run=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// the run is about two hundred cycles, so this ceiling only trips on a hang
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			test_done();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	// ==========================================
	// scenarios
	task t_reset();
		settle();
		chk(pu, 18'h3f3ff);
		chk(func_en, 18'h3ffd3);
		apb(`FGP_OFF_DIR, 1'b0, 32'h0);
		chk(q, 32'h0);
		apb(`FGP_OFF_FUNC, 1'b0, 32'h0);
		chk(q, 32'h0003_ffd3);
	endtask
	task t_port_write();
		@(posedge sys_clk);
		alt_oe  <= 18'h00004;
		alt_out <= 18'h00004;
		apb(`FGP_OFF_DIR, 1'b1, 32'h0003_ffff);
		apb(`FGP_OFF_PIN, 1'b1, 32'h0001_5555);
		settle();
		chk(pad_out, 18'h15155);
		chk(pad_oe, 18'h3fbd7);
		apb(`FGP_OFF_SET, 1'b1, 32'h0000_000a);
		settle();
		chk(pad_out, 18'h15157);
		apb(`FGP_OFF_CLR, 1'b1, 32'h0000_0101);
		settle();
		chk(pad_out, 18'h15056);
		apb(`FGP_OFF_MASK, 1'b1, 32'h0000_00ff);
		apb(`FGP_OFF_MPIN, 1'b1, 32'h0);
		settle();
		chk(pad_out, 18'h00056);
		apb(`FGP_OFF_MPIN, 1'b0, 32'h0);
		chk(q & 32'hff, 32'h0);
		apb(`FGP_OFF_MASK, 1'b1, 32'h0);
	endtask
	task t_levels();
		logic stay;
		@(posedge sys_clk);
		alt_oe  <= 18'h00000;
		ext_en  <= 18'h3ffff;
		ext_val <= 18'h2a5c3;
		apb(`FGP_OFF_DIR, 1'b1, 32'h0);
		repeat (4) settle();
		apb(`FGP_OFF_PIN, 1'b0, 32'h0);
		chk(q, 32'h0002_a5c3);
		apb(12'h040, 1'b1, 32'h031);
		apb(12'h058, 1'b1, 32'h001);
		repeat (4) settle();
		chk(lvl, 18'h2a5c2);
		// a one-cycle dip must never reach the level while the filter is on
		@(posedge sys_clk);
		ext_val <= 18'h2a583;
		@(posedge sys_clk);
		ext_val <= 18'h2a5c3;
		stay = 1'b1;
		repeat (8) begin
			@(posedge sys_clk);
			#1;
			stay = stay & lvl[6];
		end
		chk(stay, 1'b1);
		@(posedge sys_clk);
		ext_val <= 18'h2a583;
		repeat (4) settle();
		chk(lvl[6], 1'b0);
		// divider 1 ticks every fourth cycle, so a change needs far longer to pass
		apb(12'h024, 1'b1, 32'h03);
		apb(12'h024, 1'b0, 32'h0);
		chk(q, 32'h03);
		apb(12'h058, 1'b1, 32'h041);
		@(posedge sys_clk);
		ext_val <= 18'h2a5c3;
		repeat (4) settle();
		chk(lvl[6], 1'b0);
		repeat (5) settle();
		chk(lvl[6], 1'b1);
	endtask
	task t_pads();
		apb(12'h044, 1'b1, 32'h02a);
		apb(`FGP_OFF_DIR, 1'b1, 32'h2);
		apb(`FGP_OFF_PIN, 1'b1, 32'h2);
		settle();
		chk({pd[1], pu[1]}, 2'b10);
		chk(pad_oe[1], 1'b0);
		apb(`FGP_OFF_PIN, 1'b1, 32'h0);
		settle();
		chk({pad_oe[1], pad_out[1]}, 2'b10);
		apb(12'h050, 1'b1, 32'h024);
		settle();
		chk(rep[4], 1'b1);
		for (int m = 0; m < 4; m++) begin
			apb(12'h068, 1'b1, 32'h020 | (m << 8));
			settle();
			chk(i2c[1:0], (m == 3) ? 0 : m);
		end
		apb(12'h06c, 1'b1, 32'h03f);
		apb(12'h06c, 1'b0, 32'h0);
		chk(q, 32'h030);
		apb(12'h030, 1'b0, 32'h0);
		chk(err, 1'b1);
		chk(q, 32'h0);
		apb(12'h050, 1'b1, 32'h424);
		apb(12'h050, 1'b0, 32'h0);
		chk(q, 32'h024);
		apb(`FGP_OFF_DIR, 1'b1, 32'h80);
		apb(12'h05c, 1'b1, 32'hc21);
		repeat (3) settle();
		chk({hys[7], ana[7], pad_oe[7], lvl[7]}, 4'hc);
		apb(`FGP_OFF_FUNC, 1'b1, 32'h0);
		settle();
		chk(func_en, 18'h00000);
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_port_write();
		t_levels();
		t_pads();
		test_done();
	end
endmodule
`default_nettype wire
